// [vrt_pkg.sv]
package vrt_pkg;
  // ===========================================================
  // register map
  localparam logic [3:0] VRT_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] VRT_ADDR_STATUS = 4'h4;
  localparam logic [7:0] VRT_CONTROL_RESET = 8'h00;
  // ===========================================================
  // field positions
  localparam int VRT_BIT_REF_EN = 7;
  localparam int VRT_BIT_READY = 6;
  localparam int VRT_BIT_TEMP_EN = 5;
  localparam int VRT_BIT_TEMP_RNG = 4;
  localparam int VRT_CDAC_LSB = 2;
  localparam int VRT_ADC_LSB = 0;
  localparam logic [7:0] VRT_WRITE_MASK = 8'hbf;
  // ===========================================================
  // gain codes
  typedef enum logic [1:0] {
    VRT_GAIN_OFF = 2'h0,
    VRT_GAIN_1X = 2'h1,
    VRT_GAIN_2X = 2'h2,
    VRT_GAIN_4X = 2'h3
  } vrt_gain_t;
  // ===========================================================
  // software-side settling figures
  localparam int VRT_CLK_HZ = 10000000;
  localparam int VRT_TEMP_ACQ_US = 200;
  localparam int VRT_BUF_SETTLE_US = 30;
  localparam int VRT_TEMP_ACQ_CYC =
    VRT_TEMP_ACQ_US * (VRT_CLK_HZ / 1000000);
  localparam int VRT_BUF_SETTLE_CYC =
    VRT_BUF_SETTLE_US * (VRT_CLK_HZ / 1000000);
  // gain field decode into one-hot 1x/2x/4x plus on
  function automatic logic [3:0] vrt_gain_decode(input logic [1:0] code);
    case (code)
      VRT_GAIN_1X: vrt_gain_decode = 4'h9;
      VRT_GAIN_2X: vrt_gain_decode = 4'ha;
      VRT_GAIN_4X: vrt_gain_decode = 4'hc;
      default: vrt_gain_decode = 4'h0;
    endcase
  endfunction
endpackage

// [vrt_ready_track.sv]
`timescale 1ns/10ps
module vrt_ready_track
  import vrt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic std_variant_in,
  input wire logic reference_enable_in,
  input wire logic ref_settled_in,
  output logic reference_ready_flag_out
);
  // ===========================================================
  // ready flag tracking
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reference_ready_flag_out <= 1'b0;
    end else if (std_variant_in) begin
      reference_ready_flag_out <= 1'b1; // [RULE3]
    end else begin
      // set only when settled, drops next cycle on disable
      reference_ready_flag_out <= // [RULE12] [RULE14]
        reference_enable_in & ref_settled_in;
    end
  end

  AST_READY_DROP: assert property (@(posedge ref_clk_in) // [RULE14]
    disable iff (sys_rst_in)
    (!reference_enable_in && !std_variant_in)
      |=> !reference_ready_flag_out)
    else $error("ready flag did not drop after disable");
  AST_READY_STD: assert property (@(posedge ref_clk_in) // [RULE3]
    disable iff (sys_rst_in)
    std_variant_in |=> reference_ready_flag_out)
    else $error("ready flag not one in standard variant");
  AST_READY_SETTLE: assert property (@(posedge ref_clk_in) // [RULE12]
    disable iff (sys_rst_in)
    (!std_variant_in && !ref_settled_in) |=> !reference_ready_flag_out)
    else $error("ready flag set before settling");
endmodule

// [vrt_control_regs.sv]
// What this block does
// [RULE1] Bit 7 is the reference enable, one turns the reference on.
// [RULE2] Bit 6 is a read-only ready flag, one when the reference is usable.
// [RULE3] In the standard variant the ready flag always reads one.
// [RULE4] Bit 5 powers the temperature indicator.
// [RULE5] Bit 4 picks the high (one) or low (zero) temperature range.
// [RULE6] Bits 3-2 set the comparator/DAC gain: 11 4x, 10 2x, 01 1x, 00 off.
// [RULE7] Bits 1-0 set the ADC gain with the same encoding.
// [RULE8] Writable bits clear to zero on every reset.
// [RULE9] Software waits 200 us after routing the ADC to the indicator.
// [RULE10] Software leaves 200 us between indicator conversions.
// [RULE11] Software allows 30 us after enabling a reference buffer.
// [RULE12] Ready sets only after the reference has stabilised.
// [RULE13] Writes to the ready bit are ignored; it follows settle status.
// [RULE14] Clearing the enable drops ready on the next clock.
`timescale 1ns/10ps
module vrt_control_regs
  import vrt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic std_variant_in,
  input wire logic ref_settled_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic reference_enable_out,
  output logic reference_ready_flag_out,
  output logic temp_indicator_enable_out,
  output logic temp_range_select_out,
  output logic [3:0] cmp_dac_ref_gain_out,
  output logic [3:0] adc_ref_gain_out
);
  // ===========================================================
  // bus decode
  logic [7:0] ctrl;
  logic ready;
  logic access;
  logic wr_ctrl;
  logic [7:0] rd_byte;
  assign access = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_ctrl = access & wb_we_in & wb_sel_in[0]
    & (wb_adr_in == VRT_ADDR_CONTROL);

  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_in)
      VRT_ADDR_CONTROL: begin
        rd_byte = (ctrl & VRT_WRITE_MASK);
        rd_byte[VRT_BIT_READY] = ready; // [RULE2]
      end
      VRT_ADDR_STATUS: rd_byte = {7'h00, ready};
      default: rd_byte = 8'h00;
    endcase
  end

  // ===========================================================
  // bus answer: one cycle after request, dropped next cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= access;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (access && !wb_we_in) begin
      wb_dat_out <= {24'h000000, rd_byte};
    end
  end

  // ===========================================================
  // control register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= VRT_CONTROL_RESET; // [RULE8]
    end else if (wr_ctrl) begin
      ctrl <= wb_dat_in[7:0] & VRT_WRITE_MASK; // [RULE13]
    end
  end

  // ===========================================================
  // decoded controls
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reference_enable_out <= 1'b0;
      temp_indicator_enable_out <= 1'b0;
      temp_range_select_out <= 1'b0;
      cmp_dac_ref_gain_out <= 4'h0;
      adc_ref_gain_out <= 4'h0;
    end else begin
      reference_enable_out <= ctrl[VRT_BIT_REF_EN]; // [RULE1]
      temp_indicator_enable_out <= ctrl[VRT_BIT_TEMP_EN]; // [RULE4]
      temp_range_select_out <= ctrl[VRT_BIT_TEMP_RNG]; // [RULE5]
      cmp_dac_ref_gain_out <=
        vrt_gain_decode(ctrl[VRT_CDAC_LSB +: 2]); // [RULE6]
      adc_ref_gain_out <= vrt_gain_decode(ctrl[VRT_ADC_LSB +: 2]); // [RULE7]
    end
  end

  vrt_ready_track u_ready (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .std_variant_in(std_variant_in),
    .reference_enable_in(ctrl[VRT_BIT_REF_EN]),
    .ref_settled_in(ref_settled_in), // [RULE13]
    .reference_ready_flag_out(ready)
  );

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reference_ready_flag_out <= 1'b0;
    end else begin
      reference_ready_flag_out <= ready;
    end
  end

  // ===========================================================
  // checks
  sequence s_write_ctrl;
    wr_ctrl;
  endsequence
  sequence s_outputs_follow;
    ##2 ((reference_enable_out == $past(wb_dat_in[VRT_BIT_REF_EN], 2))
      && (temp_indicator_enable_out
        == $past(wb_dat_in[VRT_BIT_TEMP_EN], 2)));
  endsequence
  sequence s_request;
    access;
  endsequence
  sequence s_ack_pulse;
    ##1 wb_ack_out ##1 !wb_ack_out;
  endsequence

  AST_ENABLE_FOLLOWS: assert property (@(posedge ref_clk_in) // [RULE1]
    disable iff (sys_rst_in) s_write_ctrl |-> s_outputs_follow)
    else $error("enable outputs do not follow write");
  AST_READY_IGNORES_WRITE: assert property (@(posedge ref_clk_in) // [RULE13]
    disable iff (sys_rst_in) wr_ctrl |=> !ctrl[VRT_BIT_READY])
    else $error("ready bit stored from write");
  AST_CDAC_GAIN: assert property (@(posedge ref_clk_in) // [RULE6]
    disable iff (sys_rst_in)
    (ctrl[3:2] == 2'h3) |=> cmp_dac_ref_gain_out == 4'hc)
    else $error("comparator gain decode wrong");
  AST_CDAC_OFF: assert property (@(posedge ref_clk_in) // [RULE6]
    disable iff (sys_rst_in)
    (ctrl[VRT_CDAC_LSB +: 2] == VRT_GAIN_OFF)
      |=> cmp_dac_ref_gain_out == 4'h0)
    else $error("comparator gain not off");
  AST_CDAC_1X: assert property (@(posedge ref_clk_in) // [RULE6]
    disable iff (sys_rst_in)
    (ctrl[VRT_CDAC_LSB +: 2] == VRT_GAIN_1X)
      |=> cmp_dac_ref_gain_out == 4'h9)
    else $error("comparator gain 1x decode wrong");
  AST_CDAC_2X: assert property (@(posedge ref_clk_in) // [RULE6]
    disable iff (sys_rst_in)
    (ctrl[VRT_CDAC_LSB +: 2] == VRT_GAIN_2X)
      |=> cmp_dac_ref_gain_out == 4'ha)
    else $error("comparator gain 2x decode wrong");
  AST_ADC_OFF: assert property (@(posedge ref_clk_in) // [RULE7]
    disable iff (sys_rst_in)
    (ctrl[1:0] == 2'h0) |=> adc_ref_gain_out == 4'h0)
    else $error("adc gain not off");
  AST_ADC_1X: assert property (@(posedge ref_clk_in) // [RULE7]
    disable iff (sys_rst_in)
    (ctrl[VRT_ADC_LSB +: 2] == VRT_GAIN_1X)
      |=> adc_ref_gain_out == 4'h9)
    else $error("adc gain 1x decode wrong");
  AST_ADC_2X: assert property (@(posedge ref_clk_in) // [RULE7]
    disable iff (sys_rst_in)
    (ctrl[VRT_ADC_LSB +: 2] == VRT_GAIN_2X)
      |=> adc_ref_gain_out == 4'ha)
    else $error("adc gain 2x decode wrong");
  AST_ADC_4X: assert property (@(posedge ref_clk_in) // [RULE7]
    disable iff (sys_rst_in)
    (ctrl[VRT_ADC_LSB +: 2] == VRT_GAIN_4X)
      |=> adc_ref_gain_out == 4'hc)
    else $error("adc gain 4x decode wrong");
  AST_RANGE: assert property (@(posedge ref_clk_in) // [RULE5]
    disable iff (sys_rst_in)
    temp_range_select_out == $past(ctrl[VRT_BIT_TEMP_RNG]))
    else $error("range select lags");
  AST_TEMP_EN: assert property (@(posedge ref_clk_in) // [RULE4]
    disable iff (sys_rst_in)
    temp_indicator_enable_out == $past(ctrl[VRT_BIT_TEMP_EN]))
    else $error("temperature enable lags");
  AST_REF_EN: assert property (@(posedge ref_clk_in) // [RULE1]
    disable iff (sys_rst_in)
    reference_enable_out == $past(ctrl[VRT_BIT_REF_EN]))
    else $error("reference enable lags");
  AST_READY_OUT: assert property (@(posedge ref_clk_in) // [RULE2]
    disable iff (sys_rst_in)
    reference_ready_flag_out == $past(ready))
    else $error("ready output does not follow flag");
  AST_READY_NEEDS_EN: assert property (@(posedge ref_clk_in) // [RULE14]
    disable iff (sys_rst_in)
    (!std_variant_in && !ctrl[VRT_BIT_REF_EN]) |=> !ready)
    else $error("ready flag set while reference is off");
  AST_ACK_ONE: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  AST_ACK_TIMING: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) s_request |-> s_ack_pulse)
    else $error("ack not a single cycle after the request");
  AST_READ_READY: assert property (@(posedge ref_clk_in) // [RULE2]
    disable iff (sys_rst_in)
    (access && !wb_we_in && wb_adr_in == VRT_ADDR_CONTROL)
      |=> wb_dat_out[6] == $past(ready))
    else $error("read ready bit mismatch");
  AST_STATUS_READ: assert property (@(posedge ref_clk_in) // [RULE2]
    disable iff (sys_rst_in)
    (access && !wb_we_in && wb_adr_in == VRT_ADDR_STATUS)
      |=> wb_dat_out == {31'h0, $past(ready)})
    else $error("status read mismatch");
  AST_RESET_CLEAR: assert property (@(posedge ref_clk_in) // [RULE8]
    $fell(sys_rst_in) |-> ctrl == 8'h00)
    else $error("control not cleared by reset");
  AST_RESET_OUTPUTS: assert property (@(posedge ref_clk_in) // [RULE8]
    $fell(sys_rst_in) |-> ({reference_enable_out, temp_indicator_enable_out,
      temp_range_select_out, cmp_dac_ref_gain_out, adc_ref_gain_out} == '0))
    else $error("outputs not cleared by reset");
endmodule

// [test_voltage_ref_temp_sense_ctrl.sv]
`timescale 1ns/10ps
module test_voltage_ref_temp_sense_ctrl
  import vrt_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic std_v = 1'b0;
  logic settled = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, en, rdy, ten, trng;
  logic [3:0] cg, ag;
  logic [3:0] exp_g [4] = '{4'h0, 4'h9, 4'ha, 4'hc};
  int failures = 0;
  int tests_run = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  vrt_control_regs i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .std_variant_in(std_v), .ref_settled_in(settled), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(wen), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .reference_enable_out(en), .reference_ready_flag_out(rdy),
    .temp_indicator_enable_out(ten), .temp_range_select_out(trng),
    .cmp_dac_ref_gain_out(cg), .adc_ref_gain_out(ag));
  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    {cyc, stb, wen, adr, wdat} <= {2'b11, we, a, d};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      chk(32'h1, 32'h0);
      wrap_up();
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_fields();
    wb(1'b1, VRT_ADDR_CONTROL, 32'hff, q);
    wb(1'b0, VRT_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'hbf);
    tick(2);
    chk(32'({en, ten, trng}), 32'h7);
    wb(1'b1, VRT_ADDR_CONTROL, 32'h40, q);
    tick(2);
    chk(32'({en, rdy, ten, trng}), 32'h0);
  endtask
  task automatic t_gains();
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, VRT_ADDR_CONTROL, 32'({2'(i), 2'(3 - i)}), q);
      tick(2);
      chk(32'(cg), 32'(exp_g[i]));
      chk(32'(ag), 32'(exp_g[3 - i]));
    end
  endtask
  task automatic t_ready();
    int n;
    wb(1'b1, VRT_ADDR_CONTROL, 32'h80, q);
    tick(4);
    chk(32'(rdy), 32'h0);
    settled <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    chk(32'(rdy), 32'h1);
    if (rdy !== 1'b1) wrap_up();
    wb(1'b0, VRT_ADDR_STATUS, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b1, VRT_ADDR_CONTROL, 32'h00, q);
    tick(2);
    chk(32'(rdy), 32'h0);
    settled <= 1'b0;
  endtask
  task automatic t_std();
    std_v <= 1'b1;
    tick(3);
    chk(32'(rdy), 32'h1);
    wb(1'b0, VRT_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'h40);
    std_v <= 1'b0;
  endtask
  task automatic t_temp();
    wb(1'b1, VRT_ADDR_CONTROL, 32'h35, q);
    tick(VRT_BUF_SETTLE_CYC);
    chk(32'({ten, trng, cg, ag}), 32'h399);
    tick(VRT_TEMP_ACQ_CYC);
    wb(1'b1, VRT_ADDR_CONTROL, 32'h2e, q);
    tick(VRT_TEMP_ACQ_CYC);
    chk(32'({ten, trng, cg, ag}), 32'h2ca);
    sel <= 4'he;
    wb(1'b1, VRT_ADDR_CONTROL, 32'h00, q);
    sel <= 4'h1;
    wb(1'b0, VRT_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'h2e);
    wb(1'b1, VRT_ADDR_CONTROL, 32'h00, q);
  endtask
  task automatic t_reset();
    wb(1'b1, 4'h8, 32'hff, q);
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, VRT_ADDR_CONTROL, 32'hbf, q);
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    wb(1'b0, VRT_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'(VRT_CONTROL_RESET));
    chk(32'({en, ten, trng, cg, ag}), 32'h0);
  endtask
  initial begin
    tick(8);
    sys_rst_in <= 1'b0;
    wb(1'b0, VRT_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'h0);
    t_fields();
    t_gains();
    t_ready();
    t_std();
    t_temp();
    t_reset();
    wrap_up();
  end
endmodule
